/* File: logic/mirf_regs.sv */
// apb register bank: rx channel mask, mac irq status/mask, rx filter enable
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module mirf_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        host_error_pending,
  input  wire logic        stats_event_pending,
  output logic      [7:0]  rx_chan_irq_enable_bit,
  output logic             mac_irq,
  output logic             evt_irq,
  output logic             keep_rx_fcs,
  output logic             rx_qos_on,
  output logic             rx_single_buffer,
  output logic             copy_control_frames,
  output logic             copy_short_frames,
  output logic             copy_error_frames,
  output logic             copy_all_frames,
  output logic      [2:0]  promisc_dest_channel,
  output logic             bcast_accept,
  output logic      [2:0]  bcast_dest_channel,
  output logic             mcast_accept,
  output logic      [2:0]  mcast_dest_channel
);
  typedef struct packed {
    mirf_pkg::mirf_phase_t phase;
    logic [31:0]           rdata;
    logic                  ready;
    logic                  slverr;
    logic [31:0]           filter;
    logic [1:0]            evt_mask;
    logic                  mac_irq;
    logic                  evt_irq;
    logic [1:0]            host_sync;
    logic [1:0]            stat_sync;
    logic                  host_meta;
    logic                  stat_meta;
    logic                  host_lvl;
    logic                  stat_lvl;
  } mirf_regs_state_t;

  mirf_regs_state_t st_q;
  mirf_regs_state_t st_d;

  logic [1:0]  pend;
  logic [1:0]  mac_mask;
  logic [1:0]  evt_sticky;
  logic [7:0]  rx_mask;
  logic        wr_hit;
  logic        rx_set_we;
  logic        rx_clr_we;
  logic        mac_set_we;
  logic        mac_clr_we;
  logic        evt_clr_we;
  logic [31:0] wr_mask;

  // byte lanes from pstrb, widened to a bit mask
  function automatic logic [31:0] lanes(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic known_addr(input logic [7:0] a);
    unique case (a)
      mirf_pkg::OFS_RX_MASK_SET, mirf_pkg::OFS_RX_MASK_CLEAR,
      mirf_pkg::OFS_MAC_RAW_STATUS, mirf_pkg::OFS_MAC_MASKED_STAT,
      mirf_pkg::OFS_MAC_MASK_SET, mirf_pkg::OFS_MAC_MASK_CLEAR,
      mirf_pkg::OFS_RX_FILTER_EN, mirf_pkg::OFS_EVT_STATUS,
      mirf_pkg::OFS_EVT_MASK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // pending levels from the mac core sampled only once both late stages agree
  assign pend = {st_q.host_lvl, st_q.stat_lvl};

  // a write takes effect at the access cycle, on the same edge that raises pready
  assign wr_hit     = psel && penable && pwrite && !st_q.ready
                      && st_q.phase == mirf_pkg::MIRF_ACCESS;
  assign wr_mask    = pwdata & lanes(pstrb);
  assign rx_set_we  = wr_hit && paddr == mirf_pkg::OFS_RX_MASK_SET;
  assign rx_clr_we  = wr_hit && paddr == mirf_pkg::OFS_RX_MASK_CLEAR;
  assign mac_set_we = wr_hit && paddr == mirf_pkg::OFS_MAC_MASK_SET;
  assign mac_clr_we = wr_hit && paddr == mirf_pkg::OFS_MAC_MASK_CLEAR;
  assign evt_clr_we = wr_hit && paddr == mirf_pkg::OFS_EVT_STATUS;

  // receive channel enable mask, set and clear registers share it
  mirf_w1_mask #(
    .WIDTH (mirf_pkg::RX_CHANNELS),
    .RESET (mirf_pkg::RX_MASK_RESET)
  ) u_rx_mask (
    .pclk    (pclk),
    .presetn (presetn),
    .set_we  (rx_set_we),
    .clr_we  (rx_clr_we),
    .wdata   (wr_mask[7:0]),
    .mask_q  (rx_mask)
  );

  // host error and statistics enables
  mirf_w1_mask #(
    .WIDTH (2),
    .RESET (mirf_pkg::MAC_MASK_RESET)
  ) u_mac_mask (
    .pclk    (pclk),
    .presetn (presetn),
    .set_we  (mac_set_we),
    .clr_we  (mac_clr_we),
    .wdata   (wr_mask[1:0]),
    .mask_q  (mac_mask)
  );

  // sticky record of pending rises for the block interrupt
  mirf_evt_latch #(
    .WIDTH (mirf_pkg::EVT_W)
  ) u_evt (
    .pclk     (pclk),
    .presetn  (presetn),
    .evt      (pend),
    .clr_we   (evt_clr_we),
    .wdata    (wr_mask[1:0]),
    .sticky_q (evt_sticky)
  );

  // apb slave: one wait state so every answer comes from a flop
  always_comb
  begin
    st_d = st_q;
    st_d.host_meta = host_error_pending;
    st_d.stat_meta = stats_event_pending;
    st_d.host_sync = {st_q.host_sync[0], st_q.host_meta};
    st_d.stat_sync = {st_q.stat_sync[0], st_q.stat_meta};
    // a change counts only once the second and third stages agree,
    // so a level caught mid-settle never reaches status or irq
    if (st_q.host_sync[0] == st_q.host_sync[1])
      st_d.host_lvl = st_q.host_sync[1];
    if (st_q.stat_sync[0] == st_q.stat_sync[1])
      st_d.stat_lvl = st_q.stat_sync[1];
    st_d.ready  = 1'b0;
    st_d.slverr = 1'b0;
    st_d.mac_irq = |(pend & mac_mask);
    st_d.evt_irq = |(evt_sticky & st_q.evt_mask);
    unique case (st_q.phase)
      mirf_pkg::MIRF_IDLE:
      begin
        if (psel && !penable)
          st_d.phase = mirf_pkg::MIRF_ACCESS;
      end
      mirf_pkg::MIRF_ACCESS:
      begin
        if (!psel)
          st_d.phase = mirf_pkg::MIRF_IDLE;
        else if (st_q.ready)
          st_d.phase = mirf_pkg::MIRF_IDLE;
        else if (penable)
        begin
          st_d.ready  = 1'b1;
          st_d.slverr = !known_addr(paddr);
          st_d.rdata  = 32'h0000_0000;
          if (pwrite)
          begin
            // clear every strobed writable bit first, so zeros can be written
            if (paddr == mirf_pkg::OFS_EVT_MASK)
              st_d.evt_mask = (st_q.evt_mask & ~{2{pstrb[0]}})
                | wr_mask[1:0];
            if (paddr == mirf_pkg::OFS_RX_FILTER_EN)
              st_d.filter = (st_q.filter & ~(lanes(pstrb)
                & mirf_pkg::FILTER_WMASK))
                | (wr_mask & mirf_pkg::FILTER_WMASK);
          end
          else
          begin
            unique case (paddr)
              mirf_pkg::OFS_RX_MASK_SET, mirf_pkg::OFS_RX_MASK_CLEAR:
                st_d.rdata[7:0] = rx_mask;
              mirf_pkg::OFS_MAC_RAW_STATUS:
              begin
                st_d.rdata[mirf_pkg::BIT_HOST_ERR] = pend[1];
                st_d.rdata[mirf_pkg::BIT_STATS]    = pend[0];
              end
              mirf_pkg::OFS_MAC_MASKED_STAT:
              begin
                st_d.rdata[mirf_pkg::BIT_HOST_ERR] =
                  pend[1] & mac_mask[1];
                st_d.rdata[mirf_pkg::BIT_STATS] =
                  pend[0] & mac_mask[0];
              end
              mirf_pkg::OFS_MAC_MASK_SET, mirf_pkg::OFS_MAC_MASK_CLEAR:
                st_d.rdata[1:0] = mac_mask;
              mirf_pkg::OFS_RX_FILTER_EN:
                st_d.rdata = st_q.filter & mirf_pkg::FILTER_WMASK;
              mirf_pkg::OFS_EVT_STATUS:
                st_d.rdata[1:0] = evt_sticky;
              mirf_pkg::OFS_EVT_MASK:
                st_d.rdata[1:0] = st_q.evt_mask;
              default:
                st_d.rdata = 32'h0000_0000;
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q        <= '0;
      st_q.phase  <= mirf_pkg::MIRF_IDLE;
      st_q.filter <= mirf_pkg::FILTER_RESET;
    end
    else
      st_q <= st_d;
  end

  // filter fields drive the receive path; it applies fcs, chaining and
  // short-frame policy from these levels
  assign prdata               = st_q.rdata;
  assign pready               = st_q.ready;
  assign pslverr              = st_q.slverr;
  assign rx_chan_irq_enable_bit = rx_mask;
  assign mac_irq              = st_q.mac_irq;
  assign evt_irq              = st_q.evt_irq;
  assign keep_rx_fcs          = st_q.filter[mirf_pkg::BIT_KEEP_FCS];
  assign rx_qos_on            = st_q.filter[mirf_pkg::BIT_QOS_ON];
  assign rx_single_buffer     = st_q.filter[mirf_pkg::BIT_SINGLE_BUF];
  assign copy_control_frames  = st_q.filter[mirf_pkg::BIT_COPY_CTRL];
  assign copy_short_frames    = st_q.filter[mirf_pkg::BIT_COPY_SHORT];
  assign copy_error_frames    = st_q.filter[mirf_pkg::BIT_COPY_ERR];
  assign copy_all_frames      = st_q.filter[mirf_pkg::BIT_COPY_ALL];
  assign promisc_dest_channel =
    st_q.filter[mirf_pkg::LSB_PROMISC_CH +: 3];
  assign bcast_accept         = st_q.filter[mirf_pkg::BIT_BCAST_ACCEPT];
  assign bcast_dest_channel   = st_q.filter[mirf_pkg::LSB_BCAST_CH +: 3];
  assign mcast_accept         = st_q.filter[mirf_pkg::BIT_MCAST_ACCEPT];
  assign mcast_dest_channel   = st_q.filter[mirf_pkg::LSB_MCAST_CH +: 3];

  chk_rx_clear_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_clr_we |=> (rx_chan_irq_enable_bit & $past(wr_mask[7:0])) == 8'h00)
    else $error("rx mask clear ignored");
  chk_raw_ignores_mask: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && paddr == mirf_pkg::OFS_MAC_RAW_STATUS)
    |-> prdata[1:0] == $past(pend))
    else $error("raw status wrong");
  chk_masked_status: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && paddr == mirf_pkg::OFS_MAC_MASKED_STAT)
    |-> prdata[1:0] == ($past(pend) & $past(mac_mask)))
    else $error("masked status wrong");
  chk_mac_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mac_set_we && !mac_clr_we)
    |=> (mac_mask & $past(wr_mask[1:0])) == $past(wr_mask[1:0]))
    else $error("mac mask set failed");
  chk_mac_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mac_clr_we && !mac_set_we) |=> (mac_mask & $past(wr_mask[1:0])) == 2'h0)
    else $error("mac mask clear failed");
  chk_filter_reserved: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q.filter & ~mirf_pkg::FILTER_WMASK) == 32'h0000_0000)
    else $error("reserved filter bit set");
  chk_reserved_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && paddr == mirf_pkg::OFS_MAC_MASK_SET) |-> prdata[31:2] == '0)
    else $error("reserved bits nonzero");
  chk_irq_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 mac_irq == |($past(pend) & $past(mac_mask)))
    else $error("mac irq mismatch");
  chk_host_sync_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q.host_sync[0] != st_q.host_sync[1]) |=> $stable(st_q.host_lvl))
    else $error("host pending taken before stages agree");
  chk_stat_sync_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q.stat_sync[0] != st_q.stat_sync[1]) |=> $stable(st_q.stat_lvl))
    else $error("stats pending taken before stages agree");
  cov_evt_clear: cover property (@(posedge pclk) disable iff (!presetn)
    evt_clr_we && |evt_sticky);
  cov_filter_write: cover property (@(posedge pclk) disable iff (!presetn)
    pready && pwrite && paddr == mirf_pkg::OFS_RX_FILTER_EN);
  cov_irq_rise: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(mac_irq));
  cov_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr);
endmodule // mirf_regs

/* File: logic/mirf_pkg.sv */
// package: register map, field layout and reset values of the mac irq block
package mirf_pkg;
  // register byte offsets on the apb word grid
  localparam logic [7:0] OFS_RX_MASK_SET     = 8'h00;
  localparam logic [7:0] OFS_RX_MASK_CLEAR   = 8'h04;
  localparam logic [7:0] OFS_MAC_RAW_STATUS  = 8'h08;
  localparam logic [7:0] OFS_MAC_MASKED_STAT = 8'h0c;
  localparam logic [7:0] OFS_MAC_MASK_SET    = 8'h10;
  localparam logic [7:0] OFS_MAC_MASK_CLEAR  = 8'h14;
  localparam logic [7:0] OFS_RX_FILTER_EN    = 8'h18;
  localparam logic [7:0] OFS_EVT_STATUS      = 8'h1c;
  localparam logic [7:0] OFS_EVT_MASK        = 8'h20;
  // mac irq field positions
  localparam int BIT_STATS    = 0;
  localparam int BIT_HOST_ERR = 1;
  localparam int RX_CHANNELS  = 8;
  // receive filter enable field positions
  localparam int BIT_KEEP_FCS     = 30;
  localparam int BIT_QOS_ON       = 29;
  localparam int BIT_SINGLE_BUF   = 28;
  localparam int BIT_COPY_CTRL    = 24;
  localparam int BIT_COPY_SHORT   = 23;
  localparam int BIT_COPY_ERR     = 22;
  localparam int BIT_COPY_ALL     = 21;
  localparam int LSB_PROMISC_CH   = 16;
  localparam int BIT_BCAST_ACCEPT = 13;
  localparam int LSB_BCAST_CH     = 8;
  localparam int BIT_MCAST_ACCEPT = 5;
  localparam int LSB_MCAST_CH     = 0;
  // writable bits of the filter register, everything else reserved
  localparam logic [31:0] FILTER_WMASK = 32'h71e7_2727;
  localparam logic [31:0] FILTER_RESET = 32'h0000_0000;
  localparam logic [7:0]  RX_MASK_RESET  = 8'h00;
  localparam logic [1:0]  MAC_MASK_RESET = 2'h0;
  // frame handling figures used by the receive path
  localparam int SHORT_FRAME_BYTES = 64;
  localparam int MAX_FRAME_COUNT   = 65535;
  // event sources of the block's own interrupt status
  localparam int EVT_W = 2;
  typedef enum logic [0:0] {
    MIRF_IDLE,
    MIRF_ACCESS
  } mirf_phase_t;
endpackage

/* File: logic/mirf_w1_mask.sv */
// write-one-to-set / write-one-to-clear mask bank
`timescale 1ns/1ps
module mirf_w1_mask #(
  parameter int              WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             set_we,
  input  wire logic             clr_we,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] mask_q
);
  // refuse widths the one-word register bus cannot carry
  if (WIDTH < 1 || WIDTH > 32)
  begin : g_bad_width
    $error("mirf_w1_mask: width out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] mask;
  } mirf_mask_state_t;

  mirf_mask_state_t st_q;
  mirf_mask_state_t st_d;

  // ones set or clear, zeros leave the bit alone
  always_comb
  begin
    st_d = st_q;
    if (set_we)
      st_d.mask = st_d.mask | wdata;
    if (clr_we)
      st_d.mask = st_d.mask & ~wdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '{mask: RESET};
    else
      st_q <= st_d;
  end

  assign mask_q = st_q.mask;

  chk_zero_keeps_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_we && !set_we) |=> ((mask_q & ~$past(wdata)) == ($past(mask_q)
      & ~$past(wdata))))
    else $error("mask bit with zero written changed");
endmodule // mirf_w1_mask

/* File: logic/mirf_evt_latch.sv */
// sticky event status with write-one-to-clear; set beats clear
`timescale 1ns/1ps
module mirf_evt_latch #(
  parameter int WIDTH = 2
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] evt,
  input  wire logic             clr_we,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] sticky_q
);
  // refuse widths the one-word register bus cannot carry
  if (WIDTH < 1 || WIDTH > 32)
  begin : g_bad_width
    $error("mirf_evt_latch: width out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] sticky;
  } mirf_evt_state_t;

  mirf_evt_state_t st_q;
  mirf_evt_state_t st_d;

  // rising edge of a pending level is the event; set wins over clear
  always_comb
  begin
    st_d = st_q;
    st_d.prev = evt;
    if (clr_we)
      st_d.sticky = st_d.sticky & ~wdata;
    st_d.sticky = st_d.sticky | (evt & ~st_q.prev);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign sticky_q = st_q.sticky;

  chk_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (evt[0] && !st_q.prev[0]) |=> sticky_q[0])
    else $error("event lost against clear");
endmodule // mirf_evt_latch

/* File: tb/mac_irq_mask_and_rx_filter_regs_bench.sv */
// self-checking apb bench for the mac irq mask and rx filter register bank
`timescale 1ns/1ps
module mac_irq_mask_and_rx_filter_regs_bench;
  // writable fields of the filter enable word, all others reserved
  localparam logic [31:0] FILT_RW = 32'h71e7_2727;
  // mac mask steps: bit i set means the step writes the mask-set word
  localparam logic [7:0]  USE_SET = 8'h47;
  localparam logic [31:0] MD [8]  = '{32'h0000_0002, 32'h0000_0000,
    32'hffff_fffd, 32'h0000_0000, 32'h0000_0002, 32'hffff_fffd,
    32'h0000_0001, 32'h0000_0001};
  localparam logic [1:0]  ME [8]  = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h1, 2'h0,
    2'h1, 2'h0};
  localparam logic [31:0] FV [4]  = '{32'hffff_ffff, 32'h5555_5555,
    32'haaaa_aaaa, 32'h0000_0000};

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        host_error_pending;
  logic        stats_event_pending;
  logic [7:0]  rx_chan_irq_enable_bit;
  logic        mac_irq;
  logic        evt_irq;
  logic        keep_rx_fcs;
  logic        rx_qos_on;
  logic        rx_single_buffer;
  logic        copy_control_frames;
  logic        copy_short_frames;
  logic        copy_error_frames;
  logic        copy_all_frames;
  logic [2:0]  promisc_dest_channel;
  logic        bcast_accept;
  logic [2:0]  bcast_dest_channel;
  logic        mcast_accept;
  logic [2:0]  mcast_dest_channel;
  logic [31:0] fview;
  int          err_total;
  int          n_tests;

  mirf_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_error_pending(host_error_pending),
    .stats_event_pending(stats_event_pending),
    .rx_chan_irq_enable_bit(rx_chan_irq_enable_bit), .mac_irq(mac_irq),
    .evt_irq(evt_irq), .keep_rx_fcs(keep_rx_fcs), .rx_qos_on(rx_qos_on),
    .rx_single_buffer(rx_single_buffer),
    .copy_control_frames(copy_control_frames),
    .copy_short_frames(copy_short_frames),
    .copy_error_frames(copy_error_frames),
    .copy_all_frames(copy_all_frames),
    .promisc_dest_channel(promisc_dest_channel),
    .bcast_accept(bcast_accept), .bcast_dest_channel(bcast_dest_channel),
    .mcast_accept(mcast_accept), .mcast_dest_channel(mcast_dest_channel));

  // filter outputs folded back onto the register layout for comparison
  assign fview = {1'b0, keep_rx_fcs, rx_qos_on, rx_single_buffer, 3'h0,
    copy_control_frames, copy_short_frames, copy_error_frames,
    copy_all_frames, 2'h0, promisc_dest_channel, 2'h0, bcast_accept,
    2'h0, bcast_dest_channel, 2'h0, mcast_accept, 2'h0,
    mcast_dest_channel};

  // 40 mhz clock
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb_xfer(input logic [7:0] a, input logic wr,
    input logic [31:0] wd, input logic [3:0] st, output logic [31:0] rd,
    output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      err_total++;
      final_report();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb_xfer(a, 1'b1, d, 4'hf, rd, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        e;
    apb_xfer(a, 1'b0, 32'h0000_0000, 4'h0, rd, e);
    chk_word(rd, exp);
    chk_flag(e, 1'b0);
  endtask

  // pending levels pass a 3-flop synchroniser, the agreement flop and
  // the irq flop before they show
  task automatic set_pend(input logic h, input logic s);
    @(posedge pclk);
    host_error_pending  <= h;
    stats_event_pending <= s;
    repeat (6) @(posedge pclk);
  endtask

  initial
  begin
    logic [7:0]  exp8;
    logic [1:0]  pv;
    logic [1:0]  mv;
    logic [31:0] rd;
    logic        e;
    err_total = 0;
    n_tests = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    host_error_pending = 1'b0;
    stats_event_pending = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // every register and field comes out of reset at zero
    for (int a = 0; a <= 32; a += 4)
      rd_chk(a[7:0], 32'h0000_0000);
    chk_word(fview, 32'h0000_0000);
    // rx channel mask: walk a one through the clear word
    wr(mirf_pkg::OFS_RX_MASK_SET, 32'hffff_ffff);
    rd_chk(mirf_pkg::OFS_RX_MASK_SET, 32'h0000_00ff);
    exp8 = 8'hff;
    for (int n = 0; n < 8; n++)
    begin
      wr(mirf_pkg::OFS_RX_MASK_CLEAR, 32'h0000_0001 << n);
      exp8[n] = 1'b0;
      chk_word({24'h0, rx_chan_irq_enable_bit}, {24'h0, exp8});
      wr(mirf_pkg::OFS_RX_MASK_CLEAR, 32'h0000_0000);
      rd_chk(mirf_pkg::OFS_RX_MASK_CLEAR, {24'h0, exp8});
    end
    // mac mask set/clear sequence with zero and reserved-bit writes
    for (int i = 0; i < 8; i++)
    begin
      if (USE_SET[i])
        wr(mirf_pkg::OFS_MAC_MASK_SET, MD[i]);
      else
        wr(mirf_pkg::OFS_MAC_MASK_CLEAR, MD[i]);
      rd_chk(mirf_pkg::OFS_MAC_MASK_SET, {30'h0, ME[i]});
      rd_chk(mirf_pkg::OFS_MAC_MASK_CLEAR, {30'h0, ME[i]});
    end
    // every pending and mask combination
    for (int p = 0; p < 4; p++)
    begin
      pv = p[1:0];
      set_pend(pv[1], pv[0]);
      for (int m = 0; m < 4; m++)
      begin
        mv = m[1:0];
        wr(mirf_pkg::OFS_MAC_MASK_CLEAR, 32'h0000_0003);
        wr(mirf_pkg::OFS_MAC_MASK_SET, {30'h0, mv});
        rd_chk(mirf_pkg::OFS_MAC_RAW_STATUS, {30'h0, pv});
        rd_chk(mirf_pkg::OFS_MAC_MASKED_STAT, {30'h0, pv & mv});
        chk_flag(mac_irq, |(pv & mv));
      end
    end
    set_pend(1'b0, 1'b0);
    // filter fields, then a single byte lane write
    for (int i = 0; i < 4; i++)
    begin
      wr(mirf_pkg::OFS_RX_FILTER_EN, FV[i]);
      rd_chk(mirf_pkg::OFS_RX_FILTER_EN, FV[i] & FILT_RW);
      chk_word(fview, FV[i] & FILT_RW);
    end
    wr(mirf_pkg::OFS_RX_FILTER_EN, 32'hffff_ffff);
    apb_xfer(mirf_pkg::OFS_RX_FILTER_EN, 1'b1, 32'h0000_0000, 4'h2, rd, e);
    rd_chk(mirf_pkg::OFS_RX_FILTER_EN, 32'h71e7_0027);
    // unmapped place: error answer, zero data, nothing written
    apb_xfer(8'h24, 1'b1, 32'h0000_0000, 4'hf, rd, e);
    chk_flag(e, 1'b1);
    apb_xfer(8'hfc, 1'b0, 32'h0000_0000, 4'h0, rd, e);
    chk_flag(e, 1'b1);
    chk_word(rd, 32'h0000_0000);
    chk_word(fview, 32'h71e7_0027);
    // sticky events: raise, mask, clear
    wr(mirf_pkg::OFS_EVT_STATUS, 32'h0000_0003);
    wr(mirf_pkg::OFS_EVT_MASK, 32'h0000_0000);
    set_pend(1'b1, 1'b0);
    rd_chk(mirf_pkg::OFS_EVT_STATUS, 32'h0000_0002);
    chk_flag(evt_irq, 1'b0);
    wr(mirf_pkg::OFS_EVT_MASK, 32'h0000_0003);
    rd_chk(mirf_pkg::OFS_EVT_MASK, 32'h0000_0003);
    chk_flag(evt_irq, 1'b1);
    set_pend(1'b0, 1'b0);
    wr(mirf_pkg::OFS_EVT_STATUS, 32'h0000_0001);
    rd_chk(mirf_pkg::OFS_EVT_STATUS, 32'h0000_0002);
    wr(mirf_pkg::OFS_EVT_STATUS, 32'h0000_0002);
    rd_chk(mirf_pkg::OFS_EVT_STATUS, 32'h0000_0000);
    chk_flag(evt_irq, 1'b0);
    // a zero written into the event mask must clear that bit
    wr(mirf_pkg::OFS_EVT_MASK, 32'h0000_0001);
    rd_chk(mirf_pkg::OFS_EVT_MASK, 32'h0000_0001);
    // second reset in mid-run wipes masks and filter fields
    wr(mirf_pkg::OFS_MAC_MASK_SET, 32'h0000_0003);
    wr(mirf_pkg::OFS_RX_MASK_SET, 32'h0000_00ff);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_word(fview, 32'h0000_0000);
    chk_word({24'h0, rx_chan_irq_enable_bit}, 32'h0000_0000);
    rd_chk(mirf_pkg::OFS_MAC_MASK_SET, 32'h0000_0000);
    final_report();
  end
endmodule // mac_irq_mask_and_rx_filter_regs_bench
